// File: rtl/apc_map.svh
/*
 * Address map, field positions and reset values of the audio path
 * control register bank.
 * Assumes inclusion by its bare name from the package and the modules.
 */
`ifndef APC_MAP_SVH
`define APC_MAP_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define APC_ADDR_W     10
`define APC_DATA_W     8
`define APC_IDX_W      4
`define APC_VOL_W      6
`define APC_GAIN5_W    5
`define APC_SEL3_W     3
`define APC_GAIN2_W    2
`define APC_NUM_REGS   9

// ----------------------------------------------------------------------
// Register offsets and indices
// ----------------------------------------------------------------------
`define APC_OFS_LTX    10'h189
`define APC_OFS_RTX    10'h18a
`define APC_OFS_MIC    10'h18b
`define APC_OFS_VADC   10'h18c
`define APC_OFS_SADC   10'h18d
`define APC_OFS_VDAC   10'h18e
`define APC_OFS_ADACL  10'h18f
`define APC_OFS_ADACR  10'h190
`define APC_OFS_OUTMIX 10'h191
`define APC_IDX_LTX    4'h0
`define APC_IDX_RTX    4'h1
`define APC_IDX_MIC    4'h2
`define APC_IDX_VADC   4'h3
`define APC_IDX_SADC   4'h4
`define APC_IDX_VDAC   4'h5
`define APC_IDX_ADACL  4'h6
`define APC_IDX_ADACR  4'h7
`define APC_IDX_OUTMIX 4'h8

// ----------------------------------------------------------------------
// Reset value and writable-bit masks
// ----------------------------------------------------------------------
`define APC_RST_VAL    8'h00
`define APC_MSK_LTX    8'hff
`define APC_MSK_RTX    8'hff
`define APC_MSK_MIC    8'hdf
`define APC_MSK_VADC   8'hff
`define APC_MSK_SADC   8'h7f
`define APC_MSK_DAC    8'hbf
`define APC_MSK_OUTMIX 8'hb7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define APC_VOL_MSB    5
`define APC_VOL_LSB    0
`define APC_TX_MUTE    6
`define APC_TX_SEL     7
`define APC_MIC2_MSB   1
`define APC_MIC2_LSB   0
`define APC_MIC1_MSB   3
`define APC_MIC1_LSB   2
`define APC_HSDET      4
`define APC_IF2R       6
`define APC_IF2L       7
`define APC_VGAIN_MSB  4
`define APC_VGAIN_LSB  0
`define APC_VCLK_MSB   7
`define APC_VCLK_LSB   5
`define APC_PGA_MSB    2
`define APC_PGA_LSB    0
`define APC_PGA_EN     3
`define APC_SCLK_MSB   6
`define APC_SCLK_LSB   4
`define APC_DAC_MUTE   7
`define APC_EAR_MUTE   0
`define APC_HPR_MUTE   1
`define APC_HPL_MUTE   2
`define APC_MX_AUD     4
`define APC_MX_VOICE   5
`define APC_MX_LINE    7

// ----------------------------------------------------------------------
// Voice ADC gain decode and zero levels
// ----------------------------------------------------------------------
`define APC_VGAIN_OFS  5'sh08
`define APC_VGAIN_MAX  5'h0f
`define APC_VOL_ZERO   6'h00
`define APC_SEL3_ZERO  3'h0

`endif

// File: rtl/apc_pkg.sv
/*
 * Types shared by the audio path control register bank.
 * Assumes apc_map.svh is on the include path.
 */
`include "apc_map.svh"

package apc_pkg;
   typedef logic [`APC_ADDR_W-1:0]         apc_addr_t;
   typedef logic [`APC_DATA_W-1:0]         apc_byte_t;
   typedef logic [`APC_IDX_W-1:0]          apc_idx_t;
   typedef logic [`APC_VOL_W-1:0]          apc_vol_t;
   typedef logic [`APC_GAIN5_W-1:0]        apc_gain5_t;
   typedef logic signed [`APC_GAIN5_W-1:0] apc_db_t;
   typedef logic [`APC_SEL3_W-1:0]         apc_sel3_t;
   typedef logic [`APC_GAIN2_W-1:0]        apc_gain2_t;
endpackage

// File: rtl/apc_reg_cell.sv
/*
 * One 8-bit control register whose unimplemented bits stay zero.
 * Assumes a write strobe already qualified by the address decode.
 */
`timescale 1ns/10ps
`include "apc_map.svh"

module apc_reg_cell
#(
   parameter apc_pkg::apc_byte_t MASK = `APC_MSK_LTX
)
(
   // Clock and reset
   input  wire logic               clock_i,
   input  wire logic               arst_n_i,
   // Write port
   input  wire logic               we_i,
   input  wire apc_pkg::apc_byte_t wdata_i,
   // Stored value
   output apc_pkg::apc_byte_t      q_o
);
   import apc_pkg::*;

   // Reserved positions never store a one.
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q_o <= `APC_RST_VAL;
      end
      else if (we_i)
      begin
         q_o <= wdata_i & MASK;
      end
   end

endmodule

// File: rtl/apc_regs.sv
/*
 * Audio path control register bank: nine read/write control registers
 * that steer transmit amplifiers, microphone preamplifiers, voice and
 * stereo ADC settings, DAC volumes, output mutes and the left mixer.
 * Assumes the serial register port logic delivers one-cycle read and
 * write strobes with address and data on the same clock.
 */
`timescale 1ns/10ps
`include "apc_map.svh"

module apc_regs
(
   // Clock and reset
   input  wire logic               clock_i,
   input  wire logic               arst_n_i,
   // Register port
   input  wire apc_pkg::apc_addr_t reg_addr_i,
   input  wire logic               reg_wr_i,
   input  wire logic               reg_rd_i,
   input  wire apc_pkg::apc_byte_t reg_wdata_i,
   output apc_pkg::apc_byte_t      reg_rdata_o,
   output logic                    reg_ack_o,
   output logic                    reg_hit_o,
   // Transmit amplifiers
   output apc_pkg::apc_vol_t       left_tx_volume_o,
   output logic                    left_tx_mute_o,
   output logic                    left_tx_input_select_o,
   output apc_pkg::apc_vol_t       left_tx_level_o,
   output apc_pkg::apc_vol_t       right_tx_volume_o,
   output logic                    right_tx_mute_o,
   output logic                    right_tx_input_select_o,
   output apc_pkg::apc_vol_t       right_tx_level_o,
   // Microphones and second interface
   output apc_pkg::apc_gain2_t     second_mic_preamp_gain_o,
   output apc_pkg::apc_gain2_t     first_mic_preamp_gain_o,
   output logic                    headset_detect_enable_o,
   output logic                    second_iface_right_source_o,
   output logic                    second_iface_left_source_o,
   // Voice and stereo ADC
   output apc_pkg::apc_gain5_t     voice_adc_gain_o,
   output apc_pkg::apc_db_t        voice_adc_gain_db_o,
   output logic                    voice_adc_gain_valid_o,
   output apc_pkg::apc_sel3_t      voice_clock_input_select_o,
   output apc_pkg::apc_sel3_t      stereo_adc_pga_step_o,
   output logic                    stereo_adc_pga_enable_o,
   output apc_pkg::apc_sel3_t      stereo_adc_pga_gain_o,
   output apc_pkg::apc_sel3_t      stereo_clock_input_select_o,
   // DAC volumes
   output apc_pkg::apc_vol_t       voice_dac_volume_o,
   output logic                    voice_dac_mute_o,
   output apc_pkg::apc_vol_t       voice_dac_level_o,
   output apc_pkg::apc_vol_t       audio_dac_left_volume_o,
   output logic                    audio_dac_left_mute_o,
   output apc_pkg::apc_vol_t       audio_dac_left_level_o,
   output apc_pkg::apc_vol_t       audio_dac_right_volume_o,
   output logic                    audio_dac_right_mute_o,
   output apc_pkg::apc_vol_t       audio_dac_right_level_o,
   // Output mutes and left mixer
   output logic                    earpiece_mute_o,
   output logic                    headset_right_mute_o,
   output logic                    headset_left_mute_o,
   output logic                    left_mixer_audio_dac_o,
   output logic                    left_mixer_voice_dac_o,
   output logic                    left_mixer_line_in_o
);
   import apc_pkg::*;

   localparam apc_byte_t MASKS [`APC_NUM_REGS] = '{
      `APC_MSK_LTX, `APC_MSK_RTX, `APC_MSK_MIC, `APC_MSK_VADC,
      `APC_MSK_SADC, `APC_MSK_DAC, `APC_MSK_DAC, `APC_MSK_DAC,
      `APC_MSK_OUTMIX};

   apc_byte_t regs [`APC_NUM_REGS];
   apc_idx_t  idx;
   logic      hit;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   always_comb
   begin
      hit = 1'b1;
      idx = `APC_IDX_LTX;
      if (reg_addr_i == `APC_OFS_LTX)
         idx = `APC_IDX_LTX;
      else if (reg_addr_i == `APC_OFS_RTX)
         idx = `APC_IDX_RTX;
      else if (reg_addr_i == `APC_OFS_MIC)
         idx = `APC_IDX_MIC;
      else if (reg_addr_i == `APC_OFS_VADC)
         idx = `APC_IDX_VADC;
      else if (reg_addr_i == `APC_OFS_SADC)
         idx = `APC_IDX_SADC;
      else if (reg_addr_i == `APC_OFS_VDAC)
         idx = `APC_IDX_VDAC;
      else if (reg_addr_i == `APC_OFS_ADACL)
         idx = `APC_IDX_ADACL;
      else if (reg_addr_i == `APC_OFS_ADACR)
         idx = `APC_IDX_ADACR;
      else if (reg_addr_i == `APC_OFS_OUTMIX)
         idx = `APC_IDX_OUTMIX;
      else
         hit = 1'b0;
   end

   assign reg_hit_o = hit;

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < `APC_NUM_REGS; i++)
   begin : g_reg
      apc_reg_cell #(
         .MASK (MASKS[i])
      ) u_cell (
         .clock_i  (clock_i),
         .arst_n_i (arst_n_i),
         .we_i     (reg_wr_i && hit && (idx == apc_idx_t'(i))),
         .wdata_i  (reg_wdata_i),
         .q_o      (regs[i])
      );
   end

   // ----------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------
   // Unmapped reads answer zero; a read in the same cycle as a write returns the value from before the write.
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reg_rdata_o <= `APC_RST_VAL;
      end
      else if (reg_rd_i)
      begin
         reg_rdata_o <= hit ? regs[idx] : `APC_RST_VAL;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         reg_ack_o <= 1'b0;
      end
      else
      begin
         reg_ack_o <= reg_rd_i || reg_wr_i;
      end
   end

   // ----------------------------------------------------------------------
   // Field outputs
   // ----------------------------------------------------------------------
   assign left_tx_volume_o =
      regs[`APC_IDX_LTX][`APC_VOL_MSB:`APC_VOL_LSB];
   assign left_tx_mute_o          = regs[`APC_IDX_LTX][`APC_TX_MUTE];
   assign left_tx_input_select_o  = regs[`APC_IDX_LTX][`APC_TX_SEL];
   assign right_tx_volume_o =
      regs[`APC_IDX_RTX][`APC_VOL_MSB:`APC_VOL_LSB];
   assign right_tx_mute_o         = regs[`APC_IDX_RTX][`APC_TX_MUTE];
   assign right_tx_input_select_o = regs[`APC_IDX_RTX][`APC_TX_SEL];
   assign second_mic_preamp_gain_o =
      regs[`APC_IDX_MIC][`APC_MIC2_MSB:`APC_MIC2_LSB];
   assign first_mic_preamp_gain_o =
      regs[`APC_IDX_MIC][`APC_MIC1_MSB:`APC_MIC1_LSB];
   assign headset_detect_enable_o = regs[`APC_IDX_MIC][`APC_HSDET];
   assign second_iface_right_source_o = regs[`APC_IDX_MIC][`APC_IF2R];
   assign second_iface_left_source_o  = regs[`APC_IDX_MIC][`APC_IF2L];
   assign voice_adc_gain_o =
      regs[`APC_IDX_VADC][`APC_VGAIN_MSB:`APC_VGAIN_LSB];
   assign voice_clock_input_select_o =
      regs[`APC_IDX_VADC][`APC_VCLK_MSB:`APC_VCLK_LSB];
   assign stereo_adc_pga_step_o =
      regs[`APC_IDX_SADC][`APC_PGA_MSB:`APC_PGA_LSB];
   assign stereo_adc_pga_enable_o = regs[`APC_IDX_SADC][`APC_PGA_EN];
   assign stereo_clock_input_select_o =
      regs[`APC_IDX_SADC][`APC_SCLK_MSB:`APC_SCLK_LSB];
   assign voice_dac_volume_o =
      regs[`APC_IDX_VDAC][`APC_VOL_MSB:`APC_VOL_LSB];
   assign voice_dac_mute_o = regs[`APC_IDX_VDAC][`APC_DAC_MUTE];
   assign audio_dac_left_volume_o =
      regs[`APC_IDX_ADACL][`APC_VOL_MSB:`APC_VOL_LSB];
   assign audio_dac_left_mute_o = regs[`APC_IDX_ADACL][`APC_DAC_MUTE];
   assign audio_dac_right_volume_o =
      regs[`APC_IDX_ADACR][`APC_VOL_MSB:`APC_VOL_LSB];
   assign audio_dac_right_mute_o =
      regs[`APC_IDX_ADACR][`APC_DAC_MUTE];
   assign earpiece_mute_o      = regs[`APC_IDX_OUTMIX][`APC_EAR_MUTE];
   assign headset_right_mute_o = regs[`APC_IDX_OUTMIX][`APC_HPR_MUTE];
   assign headset_left_mute_o  = regs[`APC_IDX_OUTMIX][`APC_HPL_MUTE];
   assign left_mixer_audio_dac_o = regs[`APC_IDX_OUTMIX][`APC_MX_AUD];
   assign left_mixer_voice_dac_o = regs[`APC_IDX_OUTMIX][`APC_MX_VOICE];
   assign left_mixer_line_in_o   = regs[`APC_IDX_OUTMIX][`APC_MX_LINE];

   // ----------------------------------------------------------------------
   // Effective path levels
   // ----------------------------------------------------------------------
   // A muted path presents zero level to the analog stage.
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         left_tx_level_o         <= `APC_VOL_ZERO;
         right_tx_level_o        <= `APC_VOL_ZERO;
         voice_dac_level_o       <= `APC_VOL_ZERO;
         audio_dac_left_level_o  <= `APC_VOL_ZERO;
         audio_dac_right_level_o <= `APC_VOL_ZERO;
      end
      else
      begin
         left_tx_level_o <= left_tx_mute_o ?
            `APC_VOL_ZERO : left_tx_volume_o;
         right_tx_level_o <= right_tx_mute_o ?
            `APC_VOL_ZERO : right_tx_volume_o;
         voice_dac_level_o <= voice_dac_mute_o ?
            `APC_VOL_ZERO : voice_dac_volume_o;
         audio_dac_left_level_o <= audio_dac_left_mute_o ?
            `APC_VOL_ZERO : audio_dac_left_volume_o;
         audio_dac_right_level_o <= audio_dac_right_mute_o ?
            `APC_VOL_ZERO : audio_dac_right_volume_o;
      end
   end

   // ----------------------------------------------------------------------
   // Voice ADC gain and stereo gain stage
   // ----------------------------------------------------------------------
   // Reserved gain codes hold the decoded gain at zero and flag invalid.
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         voice_adc_gain_db_o    <= -`APC_VGAIN_OFS;
         voice_adc_gain_valid_o <= 1'b1;
      end
      else if (voice_adc_gain_o <= `APC_VGAIN_MAX)
      begin
         voice_adc_gain_db_o <=
            apc_db_t'(voice_adc_gain_o) - `APC_VGAIN_OFS;
         voice_adc_gain_valid_o <= 1'b1;
      end
      else
      begin
         voice_adc_gain_db_o    <= '0;
         voice_adc_gain_valid_o <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         stereo_adc_pga_gain_o <= `APC_SEL3_ZERO;
      end
      else
      begin
         stereo_adc_pga_gain_o <= stereo_adc_pga_enable_o ?
            stereo_adc_pga_step_o : `APC_SEL3_ZERO;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!arst_n_i);

   a_ltx_write_fields: assert property (
      reg_wr_i && reg_addr_i == `APC_OFS_LTX |=> left_tx_volume_o ==
      $past(reg_wdata_i[`APC_VOL_MSB:`APC_VOL_LSB]) &&
      left_tx_input_select_o == $past(reg_wdata_i[`APC_TX_SEL]))
      else $error("left transmit fields not taken from write");

   a_ltx_mute_level: assert property (
      left_tx_mute_o ##1 left_tx_mute_o |-> left_tx_level_o == '0)
      else $error("muted left transmit path shows a level");

   a_rtx_level: assert property (
      !right_tx_mute_o |=> right_tx_level_o == $past(right_tx_volume_o))
      else $error("unmuted right transmit level wrong");

   a_mic_routing: assert property (
      reg_wr_i && reg_addr_i == `APC_OFS_MIC |=>
      {second_iface_left_source_o, second_iface_right_source_o,
       headset_detect_enable_o, first_mic_preamp_gain_o,
       second_mic_preamp_gain_o} ==
      {$past(reg_wdata_i[`APC_IF2L]), $past(reg_wdata_i[`APC_IF2R]),
       $past(reg_wdata_i[`APC_HSDET]),
       $past(reg_wdata_i[`APC_MIC1_MSB:`APC_MIC1_LSB]),
       $past(reg_wdata_i[`APC_MIC2_MSB:`APC_MIC2_LSB])})
      else $error("microphone routing fields wrong after write");

   a_vgain_decode: assert property (
      voice_adc_gain_o <= `APC_VGAIN_MAX ##1 voice_adc_gain_valid_o |->
      voice_adc_gain_db_o + `APC_VGAIN_OFS ==
      apc_db_t'($past(voice_adc_gain_o)))
      else $error("voice ADC gain decode off");

   a_vgain_reserved: assert property (
      voice_adc_gain_o > `APC_VGAIN_MAX |=> !voice_adc_gain_valid_o)
      else $error("reserved voice gain code not flagged");

   a_clock_select: assert property (
      reg_wr_i && reg_addr_i == `APC_OFS_VADC |=>
      voice_clock_input_select_o ==
      $past(reg_wdata_i[`APC_VCLK_MSB:`APC_VCLK_LSB]))
      else $error("voice clock select not written");

   a_pga_gate: assert property (
      !stereo_adc_pga_enable_o |=> stereo_adc_pga_gain_o == '0)
      else $error("disabled stereo gain stage applies a step");

   a_dac_mute_level: assert property (
      audio_dac_left_mute_o |=> audio_dac_left_level_o == '0)
      else $error("muted left DAC shows a level");

   a_mixer_write: assert property (
      reg_wr_i && reg_addr_i == `APC_OFS_OUTMIX |=>
      left_mixer_line_in_o == $past(reg_wdata_i[`APC_MX_LINE]) &&
      earpiece_mute_o == $past(reg_wdata_i[`APC_EAR_MUTE]))
      else $error("output mixer fields not written");

   a_read_back: assert property (
      reg_rd_i && !reg_wr_i && hit |=> reg_rdata_o == $past(regs[idx]))
      else $error("read data differs from register");

   a_reserved_zero: assert property (
      reg_rd_i && reg_addr_i == `APC_OFS_SADC |=>
      reg_rdata_o == (reg_rdata_o & `APC_MSK_SADC))
      else $error("reserved bit read as one");

   c_mute_left: cover property (
      reg_wr_i && reg_addr_i == `APC_OFS_LTX &&
      reg_wdata_i[`APC_TX_MUTE] ##2 left_tx_level_o == '0);
   c_vgain_bad: cover property (!voice_adc_gain_valid_o);
   c_read_hit: cover property (reg_rd_i && hit ##1 reg_rdata_o != '0);
   c_unmapped: cover property (reg_wr_i && !hit);

endmodule

// File: tb/apc_regs_test.sv
/*
 * Self-checking bench for the audio path control register bank.
 * Assumes apc_map.svh and apc_pkg are compiled before this file.
 */
`timescale 1ns/10ps
`include "apc_map.svh"

module apc_regs_test;
   import apc_pkg::*;

   logic       clock_i, arst_n_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_hit_o;
   apc_addr_t  reg_addr_i;
   apc_byte_t  reg_wdata_i, reg_rdata_o;
   apc_vol_t   left_tx_volume_o, left_tx_level_o, right_tx_volume_o,
               right_tx_level_o, voice_dac_volume_o, voice_dac_level_o,
               audio_dac_left_volume_o, audio_dac_left_level_o,
               audio_dac_right_volume_o, audio_dac_right_level_o;
   apc_gain2_t second_mic_preamp_gain_o, first_mic_preamp_gain_o;
   apc_gain5_t voice_adc_gain_o;
   apc_db_t    voice_adc_gain_db_o;
   apc_sel3_t  voice_clock_input_select_o, stereo_adc_pga_step_o,
               stereo_adc_pga_gain_o, stereo_clock_input_select_o;
   logic       left_tx_mute_o, left_tx_input_select_o, right_tx_mute_o,
               right_tx_input_select_o, headset_detect_enable_o,
               second_iface_right_source_o, second_iface_left_source_o,
               voice_adc_gain_valid_o, stereo_adc_pga_enable_o,
               voice_dac_mute_o, audio_dac_left_mute_o,
               audio_dac_right_mute_o, earpiece_mute_o,
               headset_right_mute_o, headset_left_mute_o,
               left_mixer_audio_dac_o, left_mixer_voice_dac_o,
               left_mixer_line_in_o;
   int         mismatches, checks_done;
   apc_byte_t  got;

   apc_addr_t  adr[9] = '{`APC_OFS_LTX, `APC_OFS_RTX, `APC_OFS_MIC,
      `APC_OFS_VADC, `APC_OFS_SADC, `APC_OFS_VDAC, `APC_OFS_ADACL,
      `APC_OFS_ADACR, `APC_OFS_OUTMIX};
   apc_byte_t  msk[9] = '{8'hff, 8'hff, 8'hdf, 8'hff, 8'h7f, 8'hbf,
      8'hbf, 8'hbf, 8'hb7};

   apc_regs dut (.clock_i, .arst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
      .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_hit_o,
      .left_tx_volume_o, .left_tx_mute_o, .left_tx_input_select_o,
      .left_tx_level_o, .right_tx_volume_o, .right_tx_mute_o,
      .right_tx_input_select_o, .right_tx_level_o,
      .second_mic_preamp_gain_o, .first_mic_preamp_gain_o,
      .headset_detect_enable_o, .second_iface_right_source_o,
      .second_iface_left_source_o, .voice_adc_gain_o, .voice_adc_gain_db_o,
      .voice_adc_gain_valid_o, .voice_clock_input_select_o,
      .stereo_adc_pga_step_o, .stereo_adc_pga_enable_o,
      .stereo_adc_pga_gain_o, .stereo_clock_input_select_o,
      .voice_dac_volume_o, .voice_dac_mute_o, .voice_dac_level_o,
      .audio_dac_left_volume_o, .audio_dac_left_mute_o,
      .audio_dac_left_level_o, .audio_dac_right_volume_o,
      .audio_dac_right_mute_o, .audio_dac_right_level_o, .earpiece_mute_o,
      .headset_right_mute_o, .headset_left_mute_o, .left_mixer_audio_dac_o,
      .left_mixer_voice_dac_o, .left_mixer_line_in_o);

   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   // Field outputs of register i packed back into register bit order.
   function automatic apc_byte_t fields(int i);
      case (i)
         0: return {left_tx_input_select_o, left_tx_mute_o, left_tx_volume_o};
         1: return {right_tx_input_select_o, right_tx_mute_o,
                    right_tx_volume_o};
         2: return {second_iface_left_source_o, second_iface_right_source_o,
                    1'b0, headset_detect_enable_o, first_mic_preamp_gain_o,
                    second_mic_preamp_gain_o};
         3: return {voice_clock_input_select_o, voice_adc_gain_o};
         4: return {1'b0, stereo_clock_input_select_o,
                    stereo_adc_pga_enable_o, stereo_adc_pga_step_o};
         5: return {voice_dac_mute_o, 1'b0, voice_dac_volume_o};
         6: return {audio_dac_left_mute_o, 1'b0, audio_dac_left_volume_o};
         7: return {audio_dac_right_mute_o, 1'b0, audio_dac_right_volume_o};
         default: return {left_mixer_line_in_o, 1'b0, left_mixer_voice_dac_o,
                    left_mixer_audio_dac_o, 1'b0, headset_left_mute_o,
                    headset_right_mute_o, earpiece_mute_o};
      endcase
   endfunction

   function automatic apc_byte_t level(int i);
      case (i)
         0: return {2'h0, left_tx_level_o};
         1: return {2'h0, right_tx_level_o};
         4: return {5'h00, stereo_adc_pga_gain_o};
         5: return {2'h0, voice_dac_level_o};
         6: return {2'h0, audio_dac_left_level_o};
         7: return {2'h0, audio_dac_right_level_o};
         default: return 8'h00;
      endcase
   endfunction

   function automatic apc_byte_t exp_level(int i, apc_byte_t m);
      if (i < 2) return m[6] ? 8'h00 : {2'h0, m[5:0]};
      if (i == 4) return m[3] ? {5'h00, m[2:0]} : 8'h00;
      if (i > 4 && i < 8) return m[7] ? 8'h00 : {2'h0, m[5:0]};
      return 8'h00;
   endfunction

   task automatic chk(string what, logic [7:0] exp, logic [7:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Each access starts and ends just after a rising edge.
   task automatic wr(apc_addr_t a, apc_byte_t d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(posedge clock_i);
      #1;
      chk("write ack", 8'h01, {7'h00, reg_ack_o});
      reg_wr_i = 1'b0;
      @(posedge clock_i);
      #1;
   endtask

   task automatic rd(apc_addr_t a, output apc_byte_t d);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(posedge clock_i);
      #1;
      chk("hit", {7'h00, a >= `APC_OFS_LTX && a <= `APC_OFS_OUTMIX},
          {7'h00, reg_hit_o});
      chk("read ack", 8'h01, {7'h00, reg_ack_o});
      d = reg_rdata_o;
      reg_rd_i = 1'b0;
      @(posedge clock_i);
      #1;
   endtask

   task automatic do_reset();
      arst_n_i = 1'b0;
      repeat (4) @(posedge clock_i);
      #1;
      arst_n_i = 1'b1;
   endtask

   task automatic t_reset_values();
      chk("reset db", 8'h18, {3'h0, voice_adc_gain_db_o});
      chk("reset valid", 8'h01, {7'h00, voice_adc_gain_valid_o});
      for (int i = 0; i < 9; i++)
      begin
         rd(adr[i], got);
         chk("reset read", 8'h00, got);
         chk("reset fields", 8'h00, fields(i));
         chk("reset level", 8'h00, level(i));
      end
   endtask

   task automatic t_fields();
      apc_byte_t pat[4] = '{8'hff, 8'ha5, 8'h5a, 8'h37};
      for (int p = 0; p < 4; p++)
         for (int i = 0; i < 9; i++)
         begin
            wr(adr[i], pat[p]);
            chk("fields", pat[p] & msk[i], fields(i));
            chk("level", exp_level(i, pat[p] & msk[i]), level(i));
            rd(adr[i], got);
            chk("readback", pat[p] & msk[i], got);
         end
      chk("mixer bits", pat[3] & msk[8], fields(8));
   endtask

   task automatic t_voice_gain();
      for (int c = 0; c < 32; c++)
      begin
         wr(`APC_OFS_VADC, 8'(c));
         chk("db", c < 16 ? 8'(c - 8) & 8'h1f : 8'h00,
             {3'h0, voice_adc_gain_db_o});
         chk("valid", {7'h00, c < 16}, {7'h00, voice_adc_gain_valid_o});
      end
   endtask

   task automatic t_unmapped_and_same_cycle();
      wr(`APC_OFS_LTX, 8'h12);
      wr(10'h188, 8'hff);
      wr(10'h192, 8'hff);
      rd(10'h192, got);
      chk("unmapped read", 8'h00, got);
      rd(`APC_OFS_LTX, got);
      chk("unmapped write ignored", 8'h12, got);
      reg_addr_i = `APC_OFS_LTX;
      reg_wdata_i = 8'h34;
      reg_wr_i = 1'b1;
      reg_rd_i = 1'b1;
      @(posedge clock_i);
      #1;
      chk("read old value", 8'h12, reg_rdata_o);
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      @(posedge clock_i);
      #1;
      rd(`APC_OFS_LTX, got);
      chk("new value", 8'h34, got);
   endtask

   task automatic summarize();
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      mismatches = 0;
      checks_done = 0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 10'h000;
      reg_wdata_i = 8'h00;
      #1;
      do_reset();
      t_reset_values();
      t_fields();
      t_voice_gain();
      t_unmapped_and_same_cycle();
      do_reset();
      t_reset_values();
      summarize();
   end

   initial
   begin
      #200000;
      mismatches++;
      summarize();
   end
endmodule
